// ### verilog/usps_pkg.sv
// Constants and types for the USB port suspend control block
package usps_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] USPS_OFS_CTRL = 8'h00;
  localparam logic [7:0] USPS_OFS_STAT = 8'h04;

  // Port control register field positions
  localparam int USPS_CTRL_EN_BIT    = 2;
  localparam int USPS_CTRL_FPR_BIT   = 6;
  localparam int USPS_CTRL_SUSP_BIT  = 7;
  localparam int USPS_CTRL_PORT_BUS_RESET_BIT  = 8;
  localparam int USPS_CTRL_PWR_BIT   = 12;

  // Status register field positions
  localparam int USPS_STAT_PCD_BIT   = 2;
  localparam int USPS_STAT_STATE_LSB = 4;
  localparam int USPS_STAT_RDET_BIT  = 8;
  localparam int USPS_STAT_BLK_BIT   = 9;

  // Reset values of software controls
  localparam logic USPS_RST_EN   = 1'b0;
  localparam logic USPS_RST_FPR  = 1'b0;
  localparam logic USPS_RST_SUSP = 1'b0;
  localparam logic USPS_RST_PORT_BUS_RESET = 1'b0;
  localparam logic USPS_RST_PWR  = 1'b0;
  localparam logic USPS_RST_PCD  = 1'b0;

  // Bus line states as sampled from the port
  localparam logic [1:0] USPS_LS_J = 2'h2;
  localparam logic [1:0] USPS_LS_K = 2'h1;

  // Timing: longest resume exit, rounded down to whole cycles
  localparam int USPS_CLK_HZ         = 25000000;
  localparam int USPS_RES_EXIT_MS    = 2;
  localparam int USPS_RES_EXIT_CYC   = USPS_RES_EXIT_MS * (USPS_CLK_HZ / 1000);
  localparam int USPS_EXIT_CNT_W     = 16;

  // Reported port state: {enable, suspend}
  typedef enum logic [1:0] {
    USPS_PS_DISABLED  = 2'b00,
    USPS_PS_ENABLED   = 2'b10,
    USPS_PS_SUSPENDED = 2'b11
  } usps_port_state_t;

  // Suspend sequencer states
  typedef enum logic [1:0] {
    USPS_ST_ACTIVE    = 2'b00,
    USPS_ST_PENDING   = 2'b01,
    USPS_ST_SUSPENDED = 2'b10,
    USPS_ST_EXIT      = 2'b11
  } usps_state_t;

  // Register decode result
  typedef enum logic [1:0] {
    USPS_SEL_NONE = 2'b00,
    USPS_SEL_CTRL = 2'b01,
    USPS_SEL_STAT = 2'b10
  } usps_sel_t;

  // Downstream data beat
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } usps_ds_t;

  // Port control outputs toward the transceiver
  typedef struct packed {
    logic             resume_drive;
    logic             bus_reset;
    logic             resume_det_en;
    logic             hs_idle;
    usps_port_state_t state;
  } usps_port_t;

endpackage

// ### verilog/usps_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module usps_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Asynchronous input and filtered result
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] stable_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[g]     <= 1'b0;
          s2_q[g]     <= 1'b0;
          s3_q[g]     <= 1'b0;
          stable_o[g] <= 1'b0;
        end else begin
          s1_q[g] <= async_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // Only take a change once two late stages agree
          if (s2_q[g] == s3_q[g]) begin
            stable_o[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

endmodule // usps_sync

// ### verilog/usps_port_suspend.sv
// Suspend control for one downstream host port, with Wishbone registers
`timescale 1ns/1ns
module usps_port_suspend
  import usps_pkg::*;
#(
  parameter int RESUME_EXIT_CYC = USPS_RES_EXIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Transaction engine side
  input  wire logic        txn_busy_i,
  input  wire usps_ds_t    ds_i,
  output usps_ds_t         ds_o,
  // Port pins and control
  input  wire logic [1:0]  line_state_i,
  output usps_port_t       port_o
);

  localparam logic [USPS_EXIT_CNT_W-1:0] EXIT_LAST = USPS_EXIT_CNT_W'(RESUME_EXIT_CYC - 1);

  // Word decode, shared by read mux and write path
  function automatic usps_sel_t dec_reg(input logic [7:0] adr);
    usps_sel_t s;
    s = USPS_SEL_NONE;
    if (adr == USPS_OFS_CTRL) begin
      s = USPS_SEL_CTRL;
    end else if (adr == USPS_OFS_STAT) begin
      s = USPS_SEL_STAT;
    end
    return s;
  endfunction

  // Two-bit state code from enable and suspend
  function automatic usps_port_state_t port_state(input logic en, input logic susp);
    usps_port_state_t ps;
    if (!en) begin
      ps = USPS_PS_DISABLED;
    end else if (susp) begin
      ps = USPS_PS_SUSPENDED;
    end else begin
      ps = USPS_PS_ENABLED;
    end
    return ps;
  endfunction

  // Register state
  logic                       ack_q;
  logic [31:0]                rdat_q;
  logic                       en_q;
  logic                       fpr_q;
  logic                       port_bus_reset_q;
  logic                       pwr_q;
  logic                       pcd_q;
  usps_state_t                st_q;
  usps_state_t                st_d;
  logic [USPS_EXIT_CNT_W-1:0] exit_cnt_q;
  logic [1:0]                 ls_stable;
  logic [1:0]                 ls_prev_q;
  usps_ds_t                   ds_q;
  usps_port_t                 port_q;

  // Decoded events
  logic        req;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        lane0;
  logic        lane1;
  logic        sw_susp_set;
  logic        sw_fpr_set;
  logic        sw_fpr_clr;
  logic        sw_port_bus_reset_rise;
  logic        pwr_off;
  logic        jk_edge;
  logic        resume_seen;
  logic        exit_done;
  logic        susp_rd;
  logic        blocking;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // Line state from the pin, through the filtered synchroniser
  usps_sync #(
    .W (2)
  ) u_ls_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .async_i  (line_state_i),
    .stable_o (ls_stable)
  );

  // Bus handshake: ack one cycle after the request, writes land at the ack edge
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_q;
  assign wr_ctrl = wr_fire & (dec_reg(wb_adr_i) == USPS_SEL_CTRL);
  assign wr_stat = wr_fire & (dec_reg(wb_adr_i) == USPS_SEL_STAT);
  assign lane0   = wb_sel_i[0];
  assign lane1   = wb_sel_i[1];

  assign sw_susp_set  = wr_ctrl & lane0 & wb_dat_i[USPS_CTRL_SUSP_BIT];
  assign sw_fpr_set   = wr_ctrl & lane0 & wb_dat_i[USPS_CTRL_FPR_BIT] & ~fpr_q;
  assign sw_fpr_clr   = wr_ctrl & lane0 & ~wb_dat_i[USPS_CTRL_FPR_BIT] & fpr_q & (st_q != USPS_ST_EXIT);
  assign sw_port_bus_reset_rise = wr_ctrl & lane1 & wb_dat_i[USPS_CTRL_PORT_BUS_RESET_BIT] & ~port_bus_reset_q;
  assign pwr_off      = ~pwr_q;

  assign jk_edge     = (ls_prev_q == USPS_LS_J) && (ls_stable == USPS_LS_K);
  assign resume_seen = jk_edge & (st_q == USPS_ST_SUSPENDED) & ~fpr_q;
  assign exit_done   = (st_q == USPS_ST_EXIT) && (exit_cnt_q == EXIT_LAST);

  assign susp_rd  = (st_q == USPS_ST_SUSPENDED) & pwr_q;
  assign blocking = (st_q == USPS_ST_SUSPENDED) | (st_q == USPS_ST_EXIT);

  // Read views of both registers
  always_comb begin
    ctrl_word                     = 32'h0000_0000;
    ctrl_word[USPS_CTRL_EN_BIT]   = en_q;
    ctrl_word[USPS_CTRL_FPR_BIT]  = fpr_q & pwr_q;
    ctrl_word[USPS_CTRL_SUSP_BIT] = susp_rd;
    ctrl_word[USPS_CTRL_PORT_BUS_RESET_BIT] = port_bus_reset_q;
    ctrl_word[USPS_CTRL_PWR_BIT]  = pwr_q;
  end

  always_comb begin
    stat_word                                        = 32'h0000_0000;
    stat_word[USPS_STAT_PCD_BIT]                     = pcd_q;
    stat_word[USPS_STAT_STATE_LSB+1:USPS_STAT_STATE_LSB] = port_state(en_q, susp_rd);
    stat_word[USPS_STAT_RDET_BIT]                    = (st_q == USPS_ST_SUSPENDED);
    stat_word[USPS_STAT_BLK_BIT]                     = blocking;
  end

  // Ack and read data, both registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        case (dec_reg(wb_adr_i))
          USPS_SEL_CTRL: rdat_q <= ctrl_word;
          USPS_SEL_STAT: rdat_q <= stat_word;
          default:       rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Port power, lane 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= USPS_RST_PWR;
    end else if (wr_ctrl & lane1) begin
      pwr_q <= wb_dat_i[USPS_CTRL_PWR_BIT];
    end
  end

  // Port enable; the end of a resume does not touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= USPS_RST_EN;
    end else if (pwr_off) begin
      en_q <= 1'b0;
    end else if (wr_ctrl & lane0) begin
      en_q <= wb_dat_i[USPS_CTRL_EN_BIT];
    end
  end

  // Port reset control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_bus_reset_q <= USPS_RST_PORT_BUS_RESET;
    end else if (pwr_off) begin
      port_bus_reset_q <= 1'b0;
    end else if (wr_ctrl & lane1) begin
      port_bus_reset_q <= wb_dat_i[USPS_CTRL_PORT_BUS_RESET_BIT];
    end
  end

  // Force-resume: held through the exit so software sees it until idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpr_q <= USPS_RST_FPR;
    end else if (pwr_off | sw_port_bus_reset_rise) begin
      fpr_q <= 1'b0;
    end else if (resume_seen | sw_fpr_set) begin
      fpr_q <= 1'b1;
    end else if (exit_done) begin
      fpr_q <= 1'b0;
    end else if (sw_fpr_clr & (st_q != USPS_ST_SUSPENDED)) begin
      fpr_q <= 1'b0;
    end
  end

  // Port change detect: hardware set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcd_q <= USPS_RST_PCD;
    end else if (resume_seen) begin
      pcd_q <= 1'b1;
    end else if (wr_stat & lane0 & wb_dat_i[USPS_STAT_PCD_BIT]) begin
      pcd_q <= 1'b0;
    end
  end

  // Suspend sequencer next state
  always_comb begin
    st_d = st_q;
    if (pwr_off) begin
      st_d = USPS_ST_ACTIVE;
    end else if (sw_port_bus_reset_rise) begin
      st_d = USPS_ST_ACTIVE;
    end else begin
      case (st_q)
        USPS_ST_ACTIVE: begin
          if (sw_susp_set & en_q) begin
            st_d = USPS_ST_PENDING;
          end
        end
        USPS_ST_PENDING: begin
          if (!en_q) begin
            st_d = USPS_ST_ACTIVE;
          end else if (!txn_busy_i) begin
            st_d = USPS_ST_SUSPENDED;
          end
        end
        USPS_ST_SUSPENDED: begin
          if (sw_fpr_clr) begin
            st_d = USPS_ST_EXIT;
          end
        end
        USPS_ST_EXIT: begin
          if (exit_done) begin
            st_d = USPS_ST_ACTIVE;
          end
        end
        default: st_d = USPS_ST_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= USPS_ST_ACTIVE;
    end else begin
      st_q <= st_d;
    end
  end

  // Exit timer; the bound is the longest allowed, so idle is never late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exit_cnt_q <= '0;
    end else if (st_q == USPS_ST_EXIT) begin
      exit_cnt_q <= exit_cnt_q + 1'b1;
    end else begin
      exit_cnt_q <= '0;
    end
  end

  // Previous filtered line state for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_prev_q <= 2'h0;
    end else begin
      ls_prev_q <= ls_stable;
    end
  end

  // Downstream forwarding, one register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_q <= '0;
    end else begin
      ds_q.valid <= ds_i.valid & ~blocking;
      ds_q.data  <= ds_i.data;
    end
  end

  // Port-facing controls, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_q <= '{resume_drive: 1'b0, bus_reset: 1'b0, resume_det_en: 1'b0,
                  hs_idle: 1'b0, state: USPS_PS_DISABLED};
    end else begin
      port_q.resume_drive  <= fpr_q & (st_q == USPS_ST_SUSPENDED);
      port_q.bus_reset     <= port_bus_reset_q;
      port_q.resume_det_en <= (st_q == USPS_ST_SUSPENDED);
      port_q.hs_idle       <= exit_done;
      port_q.state         <= port_state(en_q, susp_rd);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign ds_o     = ds_q;
  assign port_o   = port_q;

endmodule // usps_port_suspend

// ### dv/usps_port_suspend_asserts.sv
// Checker for the port suspend block, bound to its top module
`timescale 1ns/1ns
module usps_chk
  import usps_pkg::*;
#(
  parameter int RESUME_EXIT_CYC = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       txn_busy_i,
  input wire usps_ds_t   ds_o,
  input wire usps_port_t port_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        run_q;
  logic [15:0] cnt_q;
  // Cycles since a forced resume ended; bus reset aborts the wait
  always_ff @(posedge clk_i) begin
    if (rst_i || port_o.hs_idle || port_o.bus_reset) begin
      run_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (run_q || $fell(port_o.resume_drive)) begin
      run_q <= 1'b1;
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_state_code: assert property (port_o.state != 2'b01) else $error("bad port state");
  chk_block_data: assert property (port_o.resume_det_en && $past(port_o.resume_det_en) |-> !ds_o.valid)
    else $error("data passed while suspended");
  chk_busy_hold: assert property ((txn_busy_i && port_o.state == 2'b10)[*2] |=> port_o.state != 2'b11)
    else $error("suspended during transaction");
  chk_rdet_on: assert property (port_o.state == 2'b11 |-> port_o.resume_det_en) else $error("no resume detect");
  chk_reset_clear: assert property ($rose(port_o.bus_reset) |-> ##[0:2] port_o.state != 2'b11)
    else $error("suspend kept over reset");
  chk_exit_time: assert property (cnt_q <= RESUME_EXIT_CYC + 3) else $error("resume exit too long");
  chk_exit_enabled: assert property (port_o.hs_idle |-> port_o.state == 2'b10) else $error("not enabled after exit");
  cov_suspend: cover property (port_o.state == 2'b11);
  cov_wake: cover property (port_o.resume_drive && port_o.resume_det_en);
  cov_exit: cover property (port_o.hs_idle);
endmodule // usps_chk

bind usps_port_suspend usps_chk #(.RESUME_EXIT_CYC(RESUME_EXIT_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .txn_busy_i(txn_busy_i), .ds_o(ds_o), .port_o(port_o)
);

// ### dv/usps_dev_model.sv
// Downstream device model: bus line states seen at the port
`timescale 1ns/1ns
module usps_dev_model
  import usps_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       wake_i,
  input  wire usps_port_t port_i,
  output logic [1:0]      line_o
);
  logic [5:0] wake_q = 6'h00;
  initial line_o = USPS_LS_J;
  // Remote wakeup holds K long enough to pass the host's input filter
  always_ff @(posedge clk_i) begin
    wake_q <= wake_i ? 6'h28 : (wake_q != 6'h00 ? wake_q - 6'h01 : 6'h00);
  end
  // Idle is J by the pull-ups; reset shows SE0, any resume shows K
  always @(posedge clk_i) begin
    if (port_i.bus_reset) line_o <= 2'h0;
    else if (port_i.resume_drive || wake_q != 6'h00) line_o <= USPS_LS_K;
    else line_o <= USPS_LS_J;
  end
endmodule // usps_dev_model

// ### dv/tb_usb_host_port_suspend_ctrl.sv
// Self-checking bench for the port suspend block
`timescale 1ns/1ns
module tb_usb_host_port_suspend_ctrl;
  import usps_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [3:0]  w;
  } usps_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0, wake = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  line;
  usps_ds_t    ds_i = '0, ds_o;
  usps_port_t  port_o;
  int          fail_count = 0, compares = 0, cyc_cnt = 0;
  usps_row_t   rows [21] = '{
    '{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h04, 0, 32'h0, 0}, '{1, 8'h00, 32'h1000, 0, 0},
    '{1, 8'h00, 32'h1004, 0, 0},
    '{0, 8'h00, 0, 32'h1004, 0}, '{0, 8'h04, 0, 32'h020, 0}, '{1, 8'h00, 32'h1084, 0, 0},
    '{0, 8'h00, 0, 32'h1084, 2}, '{0, 8'h04, 0, 32'h330, 0}, '{1, 8'h00, 32'h1004, 0, 0},
    '{0, 8'h00, 0, 32'h1084, 0}, '{1, 8'h00, 32'h10C4, 0, 0}, '{1, 8'h00, 32'h1084, 0, 0},
    '{0, 8'h00, 0, 32'h1044, 0}, '{0, 8'h00, 0, 32'h1004, 8}, '{1, 8'h00, 32'h1084, 0, 0},
    '{1, 8'h00, 32'h1104, 0, 2}, '{0, 8'h00, 0, 32'h1104, 0}, '{1, 8'h00, 32'h0084, 0, 0},
    '{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0, 0}};
  usps_port_suspend #(.RESUME_EXIT_CYC(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txn_busy_i(busy),
    .ds_i(ds_i), .ds_o(ds_o), .line_state_i(line), .port_o(port_o));
  usps_dev_model u_dev (.clk_i(clk_i), .wake_i(wake), .port_i(port_o), .line_o(line));
  always #20 clk_i = ~clk_i;
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hangs in any wait end here
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t port got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack, then releases
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_dat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_sig({3'h0, port_o}, 9'h000);
    chk_sig(ds_o, 9'h000);
    foreach (rows[i]) begin
      repeat (rows[i].w) @(posedge clk_i);
      wb(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk_reg(rd_dat, rows[i].e);
    end
    // Power must be up before enable sticks
    wb(1'b1, 8'h00, 32'h1000);
    wb(1'b1, 8'h00, 32'h1004);
    ds_i <= '{valid: 1'b1, data: 8'hA5};
    repeat (2) @(posedge clk_i);
    chk_sig(ds_o, 9'h1A5);
    busy <= 1'b1;
    wb(1'b1, 8'h00, 32'h1084);
    wb(1'b0, 8'h00, 32'h0);
    chk_reg(rd_dat, 32'h1004);
    chk_sig(ds_o, 9'h1A5);
    busy <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    chk_reg(rd_dat, 32'h1084);
    chk_sig({8'h00, ds_o.valid}, 9'h000);
    chk_sig({3'h0, port_o}, 9'h00B);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    while (port_o.resume_drive !== 1'b1) @(posedge clk_i);
    chk_sig({3'h0, port_o}, 9'h02B);
    wb(1'b0, 8'h04, 32'h0);
    chk_reg(rd_dat, 32'h334);
    wb(1'b1, 8'h04, 32'h4);
    wb(1'b0, 8'h00, 32'h0);
    chk_reg(rd_dat, 32'h10C4);
    wb(1'b1, 8'h00, 32'h1084);
    while (port_o.hs_idle !== 1'b1) @(posedge clk_i);
    chk_sig({7'h00, port_o.state}, 9'h002);
    wb(1'b0, 8'h04, 32'h0);
    chk_reg(rd_dat, 32'h020);
    wb(1'b1, 8'h00, 32'h1084);
    repeat (2) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h1104);
    repeat (2) @(posedge clk_i);
    chk_sig({3'h0, port_o}, 9'h012);
    // Reset in mid-run must bring every port control output back to idle
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_sig({3'h0, port_o}, 9'h000);
    wb(1'b0, 8'h00, 32'h0);
    chk_reg(rd_dat, 32'h0);
    finish_test();
  end
endmodule // tb_usb_host_port_suspend_ctrl
